// ==== common/frabx_pkg.sv ====
package frabx_pkg;
	// instruction word layout (14-bit core word)
	localparam int INSTR_W        = 14;
	localparam int DATA_W         = 8;
	localparam int FADDR_W        = 7;
	localparam int PC_W           = 13;
	localparam int IMM_W          = 11;
	localparam int DEST_BIT       = 7;
	localparam int PAGE_LO_BIT    = 3;
	localparam int PAGE_HI_BIT    = 4;
	localparam int PAGE_W         = 5;
	localparam int STACK_DEPTH    = 8;
	// opcode fields: bits 13:8 for file ops, 13:11 for the branch
	localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
	localparam logic [5:0] OPC_DECREMENT  = 6'h03;
	localparam logic [5:0] OPC_INCREMENT  = 6'h0A;
	localparam logic [5:0] OPC_DEC_SKIP   = 6'h0B;
	localparam logic [5:0] OPC_INC_SKIP   = 6'h0F;
	localparam logic [5:0] OPC_SWAP       = 6'h0E;
	localparam logic [2:0] OPC_BRANCH     = 3'h5;
	// reset and vector values
	localparam logic [PC_W-1:0]   PC_RESET    = 13'h0000;
	localparam logic [PC_W-1:0]   IRQ_VECTOR  = 13'h0004;
	localparam logic [DATA_W-1:0] WREG_RESET  = 8'h00;
	localparam logic [PAGE_W-1:0] PAGE_RESET  = 5'h00;

	typedef enum logic [2:0] {
		FRABX_NONE,
		FRABX_COMP,
		FRABX_DEC,
		FRABX_INC,
		FRABX_DECSZ,
		FRABX_INCSZ,
		FRABX_SWAP,
		FRABX_BRANCH
	} frabx_op_type;
endpackage

// ==== hdl/frabx_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
// combinational file-register alu for the covered operations
module frabx_alu (
	// operation and operand
	input  wire frabx_pkg::frabx_op_type op_in,
	input  wire logic [7:0]              operand_in,
	// result
	output logic [7:0]                   result_out,
	output logic                         zero_out
);
	// one result path per operation
	always_comb begin
		unique case (op_in)
			frabx_pkg::FRABX_COMP:  result_out = ~operand_in;
			frabx_pkg::FRABX_DEC,
			frabx_pkg::FRABX_DECSZ: result_out = operand_in - 8'h01;
			frabx_pkg::FRABX_INC,
			frabx_pkg::FRABX_INCSZ: result_out = operand_in + 8'h01;
			frabx_pkg::FRABX_SWAP:  result_out = {operand_in[3:0], operand_in[7:4]};
			default:                result_out = operand_in;
		endcase
		zero_out = (result_out == 8'h00);
	end
endmodule // frabx_alu
`default_nettype wire

// ==== hdl/frabx_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - complement reads file, inverts, writes w or file, updates zero flag
// - decrement writes f minus one to selected destination, zero flag only
// - increment writes f plus one to selected destination, zero flag only
// - decrement-skip leaves flags, zero result turns next word into no_operation
// - increment-skip leaves flags, zero result turns next word into no_operation
// - branch loads pc 10:0 from immediate, 12:11 from page latch 4:3
// - branch takes two instruction cycles
// - accepted interrupt starts fetching at address 0x04
// - nibble swap writes swapped value to w, and also to file when d is set, flags untouched
// - interrupt pushes only the pc onto the return stack
module frabx_exec (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	// program memory
	input  wire logic [13:0] instr_in,
	output logic [12:0]      fetch_addr_out,
	// data register file
	output logic [6:0]       file_addr_out,
	input  wire logic [7:0]  file_rdata_in,
	output logic [7:0]       file_wdata_out,
	output logic             file_we_out,
	// core context
	input  wire logic [4:0]  program_page_latch_in,
	input  wire logic        irq_req_in,
	output logic             irq_ack_out,
	output logic [7:0]       wreg_out,
	output logic             zero_flag_out,
	output logic [12:0]      stack_top_out,
	output logic [3:0]       stack_level_out
);
	typedef struct packed {
		logic [12:0] pc;
		logic [7:0]  wreg;
		logic        zero;
		logic        flush;
		logic        hold;
		logic [12:0] top;
		logic [3:0]  level;
		logic [7:0]  fwdata;
		logic        fwe;
		logic        ack;
	} frabx_state_type;

	frabx_state_type st_q, st_d;
	logic [12:0] stack_q [frabx_pkg::STACK_DEPTH];
	frabx_pkg::frabx_op_type op;
	logic [7:0] alu_res;
	logic       alu_zero;
	logic       dest_file;

	// decode the opcode field, decoding reused by the assertions too
	function automatic frabx_pkg::frabx_op_type decode(input logic [13:0] w);
		if (w[13:11] == frabx_pkg::OPC_BRANCH)
			return frabx_pkg::FRABX_BRANCH;
		unique case (w[13:8])
			frabx_pkg::OPC_COMPLEMENT: return frabx_pkg::FRABX_COMP;
			frabx_pkg::OPC_DECREMENT:  return frabx_pkg::FRABX_DEC;
			frabx_pkg::OPC_INCREMENT:  return frabx_pkg::FRABX_INC;
			frabx_pkg::OPC_DEC_SKIP:   return frabx_pkg::FRABX_DECSZ;
			frabx_pkg::OPC_INC_SKIP:   return frabx_pkg::FRABX_INCSZ;
			frabx_pkg::OPC_SWAP:       return frabx_pkg::FRABX_SWAP;
			default:                   return frabx_pkg::FRABX_NONE;
		endcase
	endfunction

	// a flushed slot executes as no_operation
	assign op        = st_q.flush ? frabx_pkg::FRABX_NONE : decode(instr_in);
	assign dest_file = instr_in[frabx_pkg::DEST_BIT];

	frabx_alu u_alu (
		.op_in      (op),
		.operand_in (file_rdata_in),
		.result_out (alu_res),
		.zero_out   (alu_zero)
	);

	// next-state logic for one instruction per clock
	always_comb begin
		st_d       = st_q;
		st_d.pc    = st_q.pc + 13'h0001;
		st_d.flush = 1'b0;
		st_d.fwe   = 1'b0;
		st_d.ack   = 1'b0;
		st_d.hold  = 1'b0;
		// the slot after a redirect is flushed but must not step past the new target
		if (st_q.hold)
			st_d.pc = st_q.pc;
		if (irq_req_in && !st_q.flush) begin
			// only the pc is pushed; w, flags and page latch stay with software
			st_d.top   = st_q.pc;
			st_d.level = st_q.level + 4'h1;
			st_d.pc    = frabx_pkg::IRQ_VECTOR;
			st_d.flush = 1'b1;
			st_d.ack   = 1'b1;
			st_d.hold  = 1'b1;
		end else begin
			unique case (op)
				frabx_pkg::FRABX_COMP, frabx_pkg::FRABX_DEC, frabx_pkg::FRABX_INC: begin
					st_d.zero = alu_zero;
					if (dest_file) begin
						st_d.fwdata = alu_res;
						st_d.fwe    = 1'b1;
					end else
						st_d.wreg = alu_res;
				end
				frabx_pkg::FRABX_DECSZ, frabx_pkg::FRABX_INCSZ: begin
					// flags untouched; skip by flushing the next fetched word
					if (dest_file) begin
						st_d.fwdata = alu_res;
						st_d.fwe    = 1'b1;
					end else
						st_d.wreg = alu_res;
					st_d.flush = alu_zero;
				end
				frabx_pkg::FRABX_SWAP: begin
					st_d.wreg = alu_res;
					if (dest_file) begin
						st_d.fwdata = alu_res;
						st_d.fwe    = 1'b1;
					end
				end
				frabx_pkg::FRABX_BRANCH: begin
					st_d.pc = {program_page_latch_in[frabx_pkg::PAGE_HI_BIT:frabx_pkg::PAGE_LO_BIT],
						instr_in[10:0]};
					st_d.flush = 1'b1;
					st_d.hold  = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// state register, synchronous reset
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_q <= '0;
			st_q.pc <= frabx_pkg::PC_RESET;
			st_q.wreg <= frabx_pkg::WREG_RESET;
		end else
			st_q <= st_d;
	end

	// return stack array; top register mirrors the newest entry
	always_ff @(posedge clk_in) begin
		if (!sys_rst_in && st_d.ack)
			stack_q[st_q.level[2:0]] <= st_q.pc;
	end

	// file writes are registered, so the file sees them one cycle late
	assign fetch_addr_out  = st_q.pc;
	assign file_addr_out   = instr_in[6:0];
	assign file_wdata_out  = st_q.fwdata;
	assign file_we_out     = st_q.fwe;
	assign irq_ack_out     = st_q.ack;
	assign wreg_out        = st_q.wreg;
	assign zero_flag_out   = st_q.zero;
	assign stack_top_out   = st_q.top;
	assign stack_level_out = st_q.level;

	// checks: file operations, expected values worked out from the operand
	chk_comp_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_COMP && !irq_req_in) |=>
			zero_flag_out == ($past(file_rdata_in) == 8'hFF))
		else $error("complement zero flag wrong");
	chk_comp_file: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_COMP && !irq_req_in && dest_file) |=>
			file_we_out && file_wdata_out == ~$past(file_rdata_in))
		else $error("complement file write wrong");
	chk_dec_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_DEC && !irq_req_in && !dest_file) |=>
			wreg_out == $past(file_rdata_in) - 8'h01)
		else $error("decrement result wrong");
	chk_inc_result: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_INC && !irq_req_in && dest_file) |=>
			file_we_out && file_wdata_out == $past(file_rdata_in) + 8'h01)
		else $error("increment result wrong");
	// skips keep the flags and drop exactly one word, with no pc hold
	chk_skip_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		((op == frabx_pkg::FRABX_DECSZ || op == frabx_pkg::FRABX_INCSZ) && !irq_req_in) |=>
			$stable(zero_flag_out))
		else $error("skip changed flags");
	chk_skip_nop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		((op == frabx_pkg::FRABX_DECSZ || op == frabx_pkg::FRABX_INCSZ) && !irq_req_in && alu_zero) |=>
			(st_q.flush && op == frabx_pkg::FRABX_NONE) ##1
			(!st_q.flush && fetch_addr_out == $past(fetch_addr_out) + 13'h0001))
		else $error("skip did not replace next word");
	// branch: target, flags and the held fetch in the flushed slot
	chk_branch_pc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_BRANCH && !irq_req_in) |=> fetch_addr_out ==
			{$past(program_page_latch_in[frabx_pkg::PAGE_HI_BIT:frabx_pkg::PAGE_LO_BIT]), $past(instr_in[10:0])})
		else $error("branch target wrong");
	chk_branch_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_BRANCH && !irq_req_in) |=>
			$stable(zero_flag_out) && $stable(wreg_out))
		else $error("branch changed flags");
	chk_branch_two: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_BRANCH && !irq_req_in) |=>
			st_q.flush ##1 (!st_q.flush && $stable(fetch_addr_out)))
		else $error("branch not two cycles");
	// interrupt entry: vector, push, refusal in a flushed slot
	chk_irq_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_in && !st_q.flush) |=> irq_ack_out && fetch_addr_out == frabx_pkg::IRQ_VECTOR &&
			stack_top_out == $past(fetch_addr_out))
		else $error("interrupt vector or push wrong");
	chk_vector_fetch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_in && !st_q.flush) |=>
			st_q.flush ##1 (!st_q.flush && fetch_addr_out == frabx_pkg::IRQ_VECTOR))
		else $error("vector word not fetched");
	chk_irq_refused: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_in && st_q.flush) |=> !irq_ack_out && $stable(stack_level_out))
		else $error("interrupt taken in flushed slot");
	chk_irq_context: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(irq_req_in && !st_q.flush) |=>
			$stable(wreg_out) && $stable(zero_flag_out) && !file_we_out)
		else $error("interrupt saved or changed context");
	// the stack array and the top register must agree after every push
	chk_stack_mirror: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		irq_ack_out |-> stack_q[stack_level_out[2:0] - 3'h1] == stack_top_out)
		else $error("stack entry differs from top");
	chk_swap_flags: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_SWAP && !irq_req_in) |=> $stable(zero_flag_out) &&
			wreg_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])})
		else $error("swap wrong");
	chk_plain_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(op == frabx_pkg::FRABX_DEC && !irq_req_in) |=>
			!st_q.flush && fetch_addr_out == $past(fetch_addr_out) + 13'h0001)
		else $error("plain op not one cycle");
	cov_branch: cover property (@(posedge clk_in) op == frabx_pkg::FRABX_BRANCH);
	cov_incskip: cover property (@(posedge clk_in) op == frabx_pkg::FRABX_INCSZ && alu_zero);
	cov_skip:   cover property (@(posedge clk_in) op == frabx_pkg::FRABX_DECSZ && alu_zero);
	cov_irq:    cover property (@(posedge clk_in) irq_ack_out);
	cov_swap:   cover property (@(posedge clk_in) op == frabx_pkg::FRABX_SWAP);
endmodule // frabx_exec
`default_nettype wire

// ==== sim/frabx_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural program memory and data register file
module frabx_mem_model (
	// clock
	input  wire logic        clk_in,
	// program memory
	input  wire logic [12:0] fetch_addr_in,
	output logic [13:0]      instr_out,
	// data register file
	input  wire logic [6:0]  file_addr_in,
	output logic [7:0]       file_rdata_out,
	input  wire logic [7:0]  file_wdata_in,
	input  wire logic        file_we_in
);
	logic [13:0] prog [8192];
	logic [7:0]  regs [128];
	logic [6:0]  waddr_q;
	// asynchronous reads, no wait states
	assign instr_out      = prog[fetch_addr_in];
	assign file_rdata_out = regs[file_addr_in];
	// write strobe trails its instruction by a cycle, so keep that address
	always @(posedge clk_in) begin
		waddr_q <= file_addr_in;
		if (file_we_in) begin
			regs[waddr_q] <= file_wdata_in;
		end
	end
endmodule // frabx_mem_model
`default_nettype wire

// ==== sim/test_file_reg_alu_branch_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
// executor against a memory model, checked cycle by cycle
module test_file_reg_alu_branch_exec;
	logic        clk_in;
	logic        sys_rst_in;
	logic [13:0] instr;
	logic [12:0] fetch;
	logic [6:0]  faddr;
	logic [7:0]  rdata;
	logic [7:0]  wdata;
	logic        we;
	logic [4:0]  page;
	logic        irq;
	logic        ack;
	logic [7:0]  wreg;
	logic        zero;
	logic [12:0] stop;
	logic [3:0]  slvl;
	int          n_errors;
	int          comparisons;

	frabx_exec u_frabx_exec (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .instr_in(instr), .fetch_addr_out(fetch),
		.file_addr_out(faddr), .file_rdata_in(rdata), .file_wdata_out(wdata), .file_we_out(we),
		.program_page_latch_in(page), .irq_req_in(irq), .irq_ack_out(ack), .wreg_out(wreg),
		.zero_flag_out(zero), .stack_top_out(stop), .stack_level_out(slvl));
	frabx_mem_model u_frabx_mem_model (.clk_in(clk_in), .fetch_addr_in(fetch), .instr_out(instr),
		.file_addr_in(faddr), .file_rdata_out(rdata), .file_wdata_in(wdata), .file_we_in(we));

	// 10 MHz instruction clock
	always #50 clk_in = ~clk_in;

	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [13:0] fop(input logic [5:0] opc, input logic d, input logic [6:0] f);
		return {opc, d, f};
	endfunction
	task automatic ld(input int a, input logic [13:0] w);
		u_frabx_mem_model.prog[a] = w;
	endtask
	task automatic rg(input int a, input logic [7:0] v);
		u_frabx_mem_model.regs[a] = v;
	endtask
	// empty program words decode as no_operation
	task automatic clear();
		sys_rst_in = 1'b1;
		for (int i = 0; i < 8192; i++)
			u_frabx_mem_model.prog[i] = 14'h0000;
	endtask
	task automatic go();
		repeat (3) @(negedge clk_in);
		chk("rst pc", 13'h0000, fetch);
		chk("rst lvl", 13'h0000, slvl);
		sys_rst_in = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic test_file_ops();
		clear();
		rg(16, 8'h5A);
		rg(18, 8'h01);
		rg(19, 8'h7F);
		rg(20, 8'hFF);
		ld(0, fop(frabx_pkg::OPC_COMPLEMENT, 1'b1, 7'h10));
		ld(1, fop(frabx_pkg::OPC_DECREMENT, 1'b0, 7'h12));
		ld(2, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h13));
		ld(3, fop(frabx_pkg::OPC_COMPLEMENT, 1'b0, 7'h14));
		ld(4, fop(frabx_pkg::OPC_INCREMENT, 1'b1, 7'h13));
		go();
		chk("z comp", 13'h0000, zero);
		chk("pc", 13'h0001, fetch);
		@(negedge clk_in);
		chk("f comp", 13'h00A5, u_frabx_mem_model.regs[16]);
		chk("w dec", 13'h0000, wreg);
		chk("z dec", 13'h0001, zero);
		@(negedge clk_in);
		chk("w inc", 13'h0080, wreg);
		chk("z inc", 13'h0000, zero);
		@(negedge clk_in);
		chk("w comp", 13'h0000, wreg);
		chk("z comp2", 13'h0001, zero);
		@(negedge clk_in);
		chk("z increment_file_op", 13'h0000, zero);
		chk("we increment_file_op", 13'h0001, we);
		@(negedge clk_in);
		chk("f inc", 13'h0080, u_frabx_mem_model.regs[19]);
		$display("test_file_ops done");
	endtask
	// skips: flags held at 1 across a nonzero result, skipped word would load 0x11
	task automatic test_skips();
		clear();
		rg(32, 8'h01);
		rg(33, 8'hFF);
		rg(34, 8'h05);
		rg(35, 8'h10);
		rg(36, 8'hFF);
		ld(0, fop(frabx_pkg::OPC_COMPLEMENT, 1'b0, 7'h21));
		ld(1, fop(frabx_pkg::OPC_INC_SKIP, 1'b0, 7'h22));
		ld(2, fop(frabx_pkg::OPC_DEC_SKIP, 1'b1, 7'h20));
		ld(3, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h23));
		ld(4, fop(frabx_pkg::OPC_INC_SKIP, 1'b0, 7'h24));
		ld(5, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h23));
		go();
		@(negedge clk_in);
		chk("w incsz", 13'h0006, wreg);
		chk("z incsz", 13'h0001, zero);
		repeat (2) @(negedge clk_in);
		chk("w skip", 13'h0006, wreg);
		chk("f decsz", 13'h0000, u_frabx_mem_model.regs[32]);
		chk("pc skip", 13'h0004, fetch);
		repeat (2) @(negedge clk_in);
		chk("w skip2", 13'h0000, wreg);
		chk("pc skip2", 13'h0006, fetch);
		$display("test_skips done");
	endtask
	task automatic test_branch_swap();
		clear();
		page = 5'h18;
		rg(48, 8'h3C);
		rg(49, 8'hFF);
		rg(50, 8'h41);
		ld(0, fop(frabx_pkg::OPC_COMPLEMENT, 1'b0, 7'h31));
		ld(1, fop(frabx_pkg::OPC_SWAP, 1'b0, 7'h30));
		ld(2, {frabx_pkg::OPC_BRANCH, 11'h7F5});
		ld(3, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h31));
		ld(8181, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h32));
		go();
		@(negedge clk_in);
		chk("w swap", 13'h00C3, wreg);
		chk("z swap", 13'h0001, zero);
		@(negedge clk_in);
		chk("pc br", 13'h1FF5, fetch);
		chk("z br", 13'h0001, zero);
		@(negedge clk_in);
		chk("w flush", 13'h00C3, wreg);
		chk("pc hold", 13'h1FF5, fetch);
		@(negedge clk_in);
		chk("w target", 13'h0042, wreg);
		page = 5'h00;
		$display("test_branch_swap done");
	endtask
	task automatic test_irq();
		clear();
		rg(49, 8'hFF);
		rg(50, 8'h41);
		ld(0, fop(frabx_pkg::OPC_COMPLEMENT, 1'b0, 7'h31));
		ld(4, fop(frabx_pkg::OPC_INCREMENT, 1'b0, 7'h32));
		go();
		irq = 1'b1;
		@(negedge clk_in);
		chk("ack", 13'h0001, ack);
		chk("vector", 13'h0004, fetch);
		chk("push", 13'h0001, stop);
		chk("lvl", 13'h0001, slvl);
		chk("w kept", 13'h0000, wreg);
		chk("z kept", 13'h0001, zero);
		@(negedge clk_in);
		chk("ack end", 13'h0000, ack);
		chk("lvl refused", 13'h0001, slvl);
		chk("pc vector", 13'h0004, fetch);
		irq = 1'b0;
		@(negedge clk_in);
		chk("w vector", 13'h0042, wreg);
		$display("test_irq done");
	endtask
	task automatic final_report();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		clk_in = 1'b0;
		sys_rst_in = 1'b1;
		page = 5'h00;
		irq = 1'b0;
		n_errors = 0;
		comparisons = 0;
		@(negedge clk_in);
		test_file_ops();
		test_skips();
		test_branch_swap();
		test_irq();
		final_report();
	end
	// watchdog, tests need well under 100 cycles
	initial begin
		#200_000;
		n_errors++;
		final_report();
	end
endmodule // test_file_reg_alu_branch_exec
`default_nettype wire
